// File: hdl/occ_pkg.sv
// Package: register map, field layout, resets and timing for calibration control
`default_nettype none
package occ_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_RDIV       = 10'h011;
  localparam logic [9:0] IDX_CAL_CTRL   = 10'h018;
  localparam logic [9:0] IDX_SYNC_DELAY = 10'h019;
  localparam logic [9:0] IDX_STATUS     = 10'h01f;
  localparam logic [9:0] IDX_UPDATE     = 10'h232;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CAL_START_POS = 0;
  localparam int CAL_DIV_LSB   = 1;
  localparam int CAL_DIV_MSB   = 2;
  localparam int UPDATE_POS    = 0;
  localparam int ADDR_IDX_LSB  = 2;
  localparam int ADDR_IDX_MSB  = 11;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CAL_CTRL_RST   = 8'h06;
  localparam logic [7:0]  SYNC_DELAY_RST = 8'h00;
  localparam logic [13:0] RDIV_RST       = 14'h0001;
  // ---------------------------------------------------------------
  // Calibration divider codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  CAL_DIV_2      = 2'h0;
  localparam logic [1:0]  CAL_DIV_4      = 2'h1;
  localparam logic [1:0]  CAL_DIV_8      = 2'h2;
  localparam logic [1:0]  CAL_DIV_16     = 2'h3;
  localparam logic [7:0]  CAL_TICKS      = 8'h40;
  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_RUN,
    CAL_DONE
  } occ_cal_state_type;
endpackage : occ_pkg
`default_nettype wire

// File: hdl/occ_divider.sv
// Module: enable-driven divider producing a one-cycle tick every ratio_m1+1 enables
`default_nettype none
module occ_divider (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [13:0] ratio_m1,
  output logic             tick
);
  typedef struct packed {
    logic [13:0] cnt;
    logic        tick;
  } occ_div_state_type;

  occ_div_state_type s_q;
  occ_div_state_type s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (en) begin
      // Ratio change takes effect mid-count; a count already at or past the new ratio wraps on the next enable
      if (s_q.cnt >= ratio_m1) begin
        s_d.cnt  = 14'h0000;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : occ_divider
`default_nettype wire

// File: hdl/occ_top.sv
// Module: oscillator calibration control with AXI4-Lite register access
//
// Operation
// - Calibration clock is the reference divided by ratio chosen in bits [2:1].
// - Divider code 00/01/10/11 gives 2/4/8/16; reset selects 16.
// - Divide-by-16 always works and gives the longest calibration.
// - Phase detector rate is reference rate divided by reference count R.
// - Calibration starts only on a 0-to-1 change of the active start bit.
// - Clearing the active start bit discards the result and drops lock.
`default_nettype none
module occ_top (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ref_present,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cal_busy,
  output logic             cal_valid,
  output logic             loop_locked,
  output logic [7:0]       sync_path_delay
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                       awrdy;
    logic                       wrdy;
    logic                       ardy;
    logic                       aw_got;
    logic [9:0]                 aw_idx;
    logic                       w_got;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [7:0]                 cal_buf;
    logic [7:0]                 cal_act;
    logic [7:0]                 sync_buf;
    logic [7:0]                 sync_act;
    logic [13:0]                rdiv_buf;
    logic [13:0]                rdiv_act;
    logic                       update;
    logic                       start_prev;
    occ_pkg::occ_cal_state_type cal_st;
    logic                       busy;
    logic [7:0]                 tick_cnt;
    logic [7:0]                 result;
    logic                       valid;
    logic                       locked;
  } occ_state_type;

  localparam occ_state_type STATE_RST = '{
    awrdy:      1'b0,
    wrdy:       1'b0,
    ardy:       1'b0,
    aw_got:     1'b0,
    aw_idx:     10'h000,
    w_got:      1'b0,
    wdata:      32'h0000_0000,
    wstrb:      4'h0,
    bvalid:     1'b0,
    bresp:      occ_pkg::RESP_OKAY,
    rvalid:     1'b0,
    rdata:      32'h0000_0000,
    rresp:      occ_pkg::RESP_OKAY,
    cal_buf:    occ_pkg::CAL_CTRL_RST,
    cal_act:    occ_pkg::CAL_CTRL_RST,
    sync_buf:   occ_pkg::SYNC_DELAY_RST,
    sync_act:   occ_pkg::SYNC_DELAY_RST,
    rdiv_buf:   occ_pkg::RDIV_RST,
    rdiv_act:   occ_pkg::RDIV_RST,
    update:     1'b0,
    start_prev: 1'b0,
    cal_st:     occ_pkg::CAL_IDLE,
    busy:       1'b0,
    tick_cnt:   8'h00,
    result:     8'h00,
    valid:      1'b0,
    locked:     1'b0
  };

  occ_state_type s_q;
  occ_state_type s_d;
  logic          rst_meta_q;
  logic          rst_sync_q;
  logic          cal_tick;
  logic          det_tick;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [13:0] cal_ratio_m1(input logic [1:0] code);
    case (code)
      occ_pkg::CAL_DIV_2:  cal_ratio_m1 = 14'h0001;
      occ_pkg::CAL_DIV_4:  cal_ratio_m1 = 14'h0003;
      occ_pkg::CAL_DIV_8:  cal_ratio_m1 = 14'h0007;
      default:             cal_ratio_m1 = 14'h000f;
    endcase
  endfunction : cal_ratio_m1

  function automatic logic [9:0] addr_idx(input logic [11:0] addr);
    addr_idx = addr[occ_pkg::ADDR_IDX_MSB:occ_pkg::ADDR_IDX_LSB];
  endfunction : addr_idx

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  // No reference, no ticks: calibration simply stalls until it returns
  occ_divider u_cal_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sync_q),
    .en       (ref_present),
    .ratio_m1 (cal_ratio_m1(s_q.cal_act[occ_pkg::CAL_DIV_MSB:occ_pkg::CAL_DIV_LSB])),
    .tick     (cal_tick)
  );

  occ_divider u_det_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_sync_q),
    .en       (ref_present),
    .ratio_m1 ((s_q.rdiv_act == 14'h0000) ? 14'h0000 : s_q.rdiv_act - 14'h0001),
    .tick     (det_tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Address and data channels, taken in either order
    if (s_axi_awvalid && s_q.awrdy) begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = addr_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end

    // Self-clearing transfer of buffered copies
    if (s_q.update) begin
      s_d.cal_act  = s_q.cal_buf;
      s_d.sync_act = s_q.sync_buf;
      s_d.rdiv_act = s_q.rdiv_buf;
      s_d.update   = 1'b0;
    end

    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = occ_pkg::RESP_OKAY;
      case (s_q.aw_idx)
        occ_pkg::IDX_CAL_CTRL: begin
          if (s_q.wstrb[0]) begin
            s_d.cal_buf = s_q.wdata[7:0];
          end
        end
        occ_pkg::IDX_SYNC_DELAY: begin
          if (s_q.wstrb[0]) begin
            s_d.sync_buf = s_q.wdata[7:0];
          end
        end
        occ_pkg::IDX_RDIV: begin
          if (s_q.wstrb[0]) begin
            s_d.rdiv_buf[7:0] = s_q.wdata[7:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.rdiv_buf[13:8] = s_q.wdata[13:8];
          end
        end
        occ_pkg::IDX_UPDATE: begin
          if (s_q.wstrb[0] && s_q.wdata[occ_pkg::UPDATE_POS]) begin
            s_d.update = 1'b1;
          end
        end
        occ_pkg::IDX_STATUS: begin
          // Read-only; write accepted and ignored
        end
        default: begin
          s_d.bresp = occ_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.ardy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = occ_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      case (addr_idx(s_axi_araddr))
        occ_pkg::IDX_CAL_CTRL:   s_d.rdata[7:0]  = s_q.cal_buf;
        occ_pkg::IDX_SYNC_DELAY: s_d.rdata[7:0]  = s_q.sync_buf;
        occ_pkg::IDX_RDIV:       s_d.rdata[13:0] = s_q.rdiv_buf;
        occ_pkg::IDX_UPDATE:     s_d.rdata[0]    = s_q.update;
        occ_pkg::IDX_STATUS: begin
          s_d.rdata[0]    = (s_q.cal_st == occ_pkg::CAL_RUN);
          s_d.rdata[1]    = s_q.valid;
          s_d.rdata[2]    = s_q.locked;
          s_d.rdata[15:8] = s_q.result;
        end
        default: begin
          s_d.rresp = occ_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Calibration sequencer, driven only by the active copy
    s_d.start_prev = s_q.cal_act[occ_pkg::CAL_START_POS];
    if (!s_q.cal_act[occ_pkg::CAL_START_POS]) begin
      // Result is thrown away; the loop must be recalibrated to relock
      s_d.cal_st   = occ_pkg::CAL_IDLE;
      s_d.valid    = 1'b0;
      s_d.result   = 8'h00;
      s_d.locked   = 1'b0;
      s_d.tick_cnt = 8'h00;
    end else begin
      case (s_q.cal_st)
        occ_pkg::CAL_IDLE: begin
          if (!s_q.start_prev) begin
            s_d.cal_st   = occ_pkg::CAL_RUN;
            s_d.tick_cnt = 8'h00;
            s_d.result   = 8'h00;
          end
        end
        occ_pkg::CAL_RUN: begin
          // Fixed tick count, so a slower clock means a longer run
          if (cal_tick) begin
            s_d.tick_cnt = s_q.tick_cnt + 8'h01;
            if (s_q.tick_cnt == occ_pkg::CAL_TICKS - 8'h01) begin
              s_d.cal_st = occ_pkg::CAL_DONE;
              s_d.valid  = 1'b1;
              s_d.locked = 1'b1;
            end
          end
          if (det_tick && s_q.result != 8'hff) begin
            s_d.result = s_q.result + 8'h01;
          end
        end
        occ_pkg::CAL_DONE: begin
        end
        default: begin
          s_d.cal_st = occ_pkg::CAL_IDLE;
        end
      endcase
    end

    // Ready flags registered so every port comes from a flop
    s_d.awrdy = !s_d.aw_got && !s_d.bvalid;
    s_d.wrdy  = !s_d.w_got && !s_d.bvalid;
    s_d.ardy  = !s_d.rvalid;
    s_d.busy  = (s_d.cal_st == occ_pkg::CAL_RUN);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready   = s_q.awrdy;
  assign s_axi_wready    = s_q.wrdy;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_arready   = s_q.ardy;
  assign s_axi_rdata     = s_q.rdata;
  assign s_axi_rresp     = s_q.rresp;
  assign s_axi_rvalid    = s_q.rvalid;
  assign cal_busy        = s_q.busy;
  assign cal_valid       = s_q.valid;
  assign loop_locked     = s_q.locked;
  assign sync_path_delay = s_q.sync_act;
endmodule : occ_top
`default_nettype wire

// File: testbench/occ_checker.sv
// Checker: bus answer and calibration properties at the block's ports
`default_nettype none
module occ_checker (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       ref_present,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       cal_busy,
  input wire logic       cal_valid,
  input wire logic       loop_locked,
  input wire logic [7:0] sync_path_delay
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Length of the latest run, held after it ends
  logic [11:0] run_q;
  logic        busy_d_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_q    <= 12'h000;
      busy_d_q <= 1'b0;
    end else begin
      run_q    <= cal_busy ? (busy_d_q ? run_q + 12'h001 : 12'h001) : run_q;
      busy_d_q <= cal_busy;
    end
  end
  // Shortest run is 64 ticks of divide-by-2, first tick phase unknown
  AST_RUN_LENGTH: assert property ($rose(cal_valid) |-> run_q >= 12'h07e)
    else $error("calibration ended too early");
  AST_VALID_AFTER_RUN: assert property ($rose(cal_valid) |-> $past(cal_busy))
    else $error("result without a run");
  AST_BUSY_NOT_VALID: assert property (cal_busy |-> !cal_valid)
    else $error("result held during a run");
  AST_LOCK_WITH_VALID: assert property (cal_valid |-> loop_locked)
    else $error("result held without lock");
  AST_NO_REF_HOLD: assert property ((!ref_present && cal_busy) [*4] |=> cal_busy)
    else $error("run advanced without reference");
  AST_SYNC_ON_UPDATE: assert property (!$stable(sync_path_delay) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("active copy moved without update");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule : occ_checker
bind occ_top occ_checker u_chk (.clk_sys, .nrst, .ref_present, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .cal_busy, .cal_valid, .loop_locked, .sync_path_delay);
`default_nettype wire

// File: testbench/occ_top_tb.sv
// Testbench: register access and calibration sequences for the control block
`default_nettype none
module occ_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, ref_present, cal_busy, cal_valid, loop_locked;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  sync_path_delay;
  logic [31:0] d;
  logic [1:0]  r, b;
  int          num_errors, n_checks, n;
  occ_top u_dut (.clk_sys, .nrst, .ref_present, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cal_busy, .cal_valid, .loop_locked, .sync_path_delay);
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (!aw && !w && s_axi_bvalid) break;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    b = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [9:0] idx);
    logic a;
    a = 1'b1;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (!a && s_axi_rvalid) break;
      if (a && s_axi_arready) begin
        a = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_valid(input int lim);
    n = 0;
    while (cal_valid !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_valid
  // Two updates so the active start bit really goes 0 then 1
  task automatic cal(input logic [1:0] code);
    wr(occ_pkg::IDX_CAL_CTRL, {29'h0, code, 1'b0});
    wr(occ_pkg::IDX_UPDATE, 32'h1);
    wr(occ_pkg::IDX_CAL_CTRL, {29'h0, code, 1'b1});
    wr(occ_pkg::IDX_UPDATE, 32'h1);
    wait_valid(3000);
    chk("cal_time_min", n >= (63 << (code + 1)), 1'b1);
    chk("cal_time_max", n <= (64 << (code + 1)) + 40, 1'b1);
    rd(occ_pkg::IDX_STATUS);
    chk("status_flags", d[2:0], 3'h6);
    chk("cal_result", d[15:8] + 2 >= (8 << code) && d[15:8] <= (8 << code) + 2, 1'b1);
  endtask : cal
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #150000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    ref_present = 1'b1; // Reference up before any start
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(occ_pkg::IDX_CAL_CTRL);
    chk("cal_ctrl_reset", d, 32'h6);
    rd(10'h3ff);
    chk("unmapped_resp", r, 2'h2);
    wr(10'h3ff, 32'h1);
    chk("unmapped_wresp", b, 2'h2);
    wr(occ_pkg::IDX_SYNC_DELAY, 32'ha5);
    chk("sync_wresp", b, 2'h0);
    chk("sync_before_update", sync_path_delay, 8'h00);
    rd(occ_pkg::IDX_SYNC_DELAY);
    chk("sync_buffered", d, 32'ha5);
    wr(occ_pkg::IDX_UPDATE, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("sync_after_update", sync_path_delay, 8'ha5);
    rd(occ_pkg::IDX_UPDATE);
    chk("update_self_clear", d, 32'h0);
    // R of 16 keeps the detector below 12.5 MHz, so every code is allowed
    wr(occ_pkg::IDX_RDIV, 32'h10);
    for (int c = 0; c < 4; c++) begin
      cal(c[1:0]);
    end
    // Clearing the buffered copy alone must not discard the result
    wr(occ_pkg::IDX_CAL_CTRL, 32'h6);
    chk("valid_after_write", cal_valid, 1'b1);
    wr(occ_pkg::IDX_UPDATE, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("valid_discarded", {cal_valid, loop_locked}, 2'h0);
    wr(occ_pkg::IDX_CAL_CTRL, 32'h7);
    repeat (3) @(posedge clk_sys);
    chk("no_start_on_write", cal_busy, 1'b0);
    ref_present <= 1'b0;
    wr(occ_pkg::IDX_UPDATE, 32'h1);
    repeat (300) @(posedge clk_sys);
    chk("stall_without_ref", {cal_busy, cal_valid}, 2'h2);
    ref_present <= 1'b1;
    wait_valid(1200);
    chk("done_after_ref", cal_valid, 1'b1);
    report_and_stop();
  end
endmodule : occ_top_tb
`default_nettype wire
